/* File: ahb_master_model.sv */
// ahb master model issuing single transfers
`timescale 1ns/100ps
`default_nettype none
module ahb_master_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [1:0] resp_i,
  input wire logic [31:0] rdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial
  begin
    hsel_o = 1'h0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'h0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [2:0] sz, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err, output int w);
    @(posedge clk_i);
    #1;
    hsel_o = 1'h1;
    htrans_o = 2'h2;
    haddr_o = a;
    hwrite_o = wr;
    hsize_o = sz;
    @(posedge clk_i);
    while (ready_i !== 1'h1)
      @(posedge clk_i);
    #1;
    hsel_o = 1'h0;
    htrans_o = 2'h0;
    haddr_o = ~a;
    hwdata_o = wd;
    w = 0;
    @(posedge clk_i);
    while (ready_i !== 1'h1 && w < 9)
    begin
      w++;
      @(posedge clk_i);
    end
    rd = rdata_i;
    err = resp_i === 2'h1;
    #1;
    hwdata_o = ~wd;
  endtask
endmodule
`default_nettype wire

/* File: edac_onchip_sram_ahb.v */
// on-chip sram with single-correct double-detect check bits behind an ahb slave port
`timescale 1ns/100ps
`default_nettype none
`include "edac_sram_consts.vh"

// Behaviour
// - each 32-bit word carries 7 check bits; single errors corrected, doubles detected.
// - capacity set at build time, at least one kilobyte, power-of-two sizes.
// - correction off: writes go straight in, reads leave as soon as fetched.
// - correction on: full-word store encodes 7 check bits, stored alongside, no waits.
// - correction on: subword store reads, merges, re-encodes, writes back; two waits.
// - reads take one wait uncorrected, two corrected; word and subword reads alike.
// - input pipeline option adds one wait to reads and, with correction on, to subword stores.
// - read data decoded the cycle after fetch, driven the next unless uncorrectable.
// - syndrome from stored versus recomputed check bits; single errors fixed with no error response.
// - double errors abort the transfer with a two-cycle error response.
// - write bypass stores the test check bits instead of the computed ones.
// - read bypass copies fetched check bits into test check bits, even on doubles.
// - optional 8-bit counter counts corrected single errors, saturating at all ones.
// - writing one to a counter bit clears it; zero leaves it.
// - corrected-error output pulses high one cycle per single error.
// - autoscrub option writes corrected word with fresh check bits back on reads.
// - scrub write-back happens in the decode cycle and adds no wait states.
// - correction build option zero removes correction logic; plain memory remains.
// - config word: write bypass bit 9, read bypass 8, enable 7, test bits 6..0.
// - reset clears enable, bypass bits and counter; test check bits keep value.
module edac_onchip_sram_ahb #(
  parameter KBYTES = 1,
  parameter EDAC_EN = 1,
  parameter PIPE = 0,
  parameter AUTOSCRUB = 0,
  parameter ERRCNT_EN = 1
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg hreadyout_o,
  output reg [1:0] hresp_o,
  output wire [31:0] hrdata_o,
  input wire cfg_wr_i,
  input wire [31:0] cfg_wdata_i,
  output wire [31:0] cfg_rdata_o,
  output wire ce_o
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function integer clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      clog2 = 0;
      while (v > 0)
      begin
        clog2 = clog2 + 1;
        v = v >> 1;
      end
    end
  endfunction
  // idx-th weight-three column of the check matrix
  function [6:0] col_code;
    input integer idx;
    integer v;
    integer n;
    begin
      col_code = 7'h00;
      n = 0;
      for (v = 0; v < 128; v = v + 1)
      begin
        if (weight(v[6:0]) == 3'h3)
        begin
          if (n == idx)
            col_code = v[6:0];
          n = n + 1;
        end
      end
    end
  endfunction
  function [6:0] encode;
    input [31:0] d;
    integer j;
    begin
      encode = 7'h00;
      for (j = 0; j < 32; j = j + 1)
        if (d[j])
          encode = encode ^ col_code(j);
    end
  endfunction
  function [2:0] weight;
    input [6:0] s;
    integer b;
    begin
      weight = 3'h0;
      for (b = 0; b < 7; b = b + 1)
        weight = weight + {2'h0, s[b]};
    end
  endfunction
  function [31:0] flip_mask;
    input [6:0] s;
    integer j;
    begin
      flip_mask = 32'h00000000;
      for (j = 0; j < 32; j = j + 1)
        if (s == col_code(j))
          flip_mask[j] = 1'b1;
    end
  endfunction
  function [3:0] byte_en;
    input [2:0] size;
    input [1:0] off;
    begin
      case (size)
        3'h0: byte_en = 4'h1 << off;
        3'h1: byte_en = off[1] ? 4'hC : 4'h3;
        default: byte_en = 4'hF;
      endcase
    end
  endfunction
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // ------------------------------------------------------------
  // sizing and states
  // ------------------------------------------------------------
  localparam DEPTH = KBYTES * `WORDS_PER_KB;
  localparam AW = clog2(DEPTH);
  localparam [31:0] SIZE_LOG2 = clog2(KBYTES);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PIPE = 4'h1;
  localparam [3:0] S_RD = 4'h2;
  localparam [3:0] S_DEC = 4'h3;
  localparam [3:0] S_DONE = 4'h4;
  localparam [3:0] S_RMW_RD = 4'h5;
  localparam [3:0] S_RMW_DEC = 4'h6;
  localparam [3:0] S_RMW_WR = 4'h7;
  localparam [3:0] S_ERR1 = 4'h8;
  localparam [3:0] S_ERR2 = 4'h9;
  reg [`WORD_W-1:0] mem [0:DEPTH-1];
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [AW-1:0] addr_q;
  reg [3:0] be_q;
  reg wr_q;
  reg dp_wr_q;
  reg [`WORD_W-1:0] mem_q;
  reg [31:0] out_q;
  reg en_q;
  reg rb_q;
  reg wb_q;
  reg [6:0] tcb_q;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg ce_q;

  wire edac_on = (EDAC_EN != 0) && en_q;
  wire take = hreadyout_o && hsel_i && hready_i && htrans_i[1];
  wire subword = (hsize_i < `HSIZE_WORD);
  wire deep = (PIPE != 0);

  // ------------------------------------------------------------
  // syndrome decode of the fetched word
  // ------------------------------------------------------------
  wire [6:0] syn = mem_q[`CHK_MSB:`CHK_LSB] ^ encode(mem_q[31:0]);
  wire [31:0] flips = flip_mask(syn);
  wire [31:0] corrected = mem_q[31:0] ^ flips;
  wire any_err = (syn != 7'h00);
  wire single_err = any_err && ((flips != 32'h00000000) || (weight(syn) == 3'h1));
  wire double_err = any_err && !single_err;
  wire decoding = edac_on && ((state_q == S_DEC) || (state_q == S_RMW_DEC));
  wire scrub = (AUTOSCRUB != 0) && (state_q == S_DEC) && edac_on && single_err;
  wire [31:0] rmw_data = merge(out_q, hwdata_i, be_q);

  // ------------------------------------------------------------
  // ahb handshake outputs
  // ------------------------------------------------------------
  always @*
  begin
    hresp_o = ((state_q == S_ERR1) || (state_q == S_ERR2)) ? `HRESP_ERROR : `HRESP_OKAY;
    case (state_q)
      S_IDLE, S_DONE, S_RMW_WR, S_ERR2: hreadyout_o = 1'b1;
      default: hreadyout_o = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // transfer sequencing
  // ------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE, S_DONE, S_RMW_WR, S_ERR2:
      begin
        if (!take)
          state_d = S_IDLE;
        else if (!hwrite_i)
          state_d = deep ? S_PIPE : S_RD;
        else if (edac_on && subword)
          state_d = deep ? S_PIPE : S_RMW_RD;
        else
          state_d = S_IDLE;
      end
      S_PIPE: state_d = wr_q ? S_RMW_RD : S_RD;
      S_RD: state_d = edac_on ? S_DEC : S_DONE;
      S_DEC: state_d = double_err ? S_ERR1 : S_DONE;
      S_RMW_RD: state_d = S_RMW_DEC;
      S_RMW_DEC: state_d = double_err ? S_ERR1 : S_RMW_WR;
      S_ERR1: state_d = S_ERR2;
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= S_IDLE;
      addr_q <= {AW{1'b0}};
      be_q <= 4'h0;
      wr_q <= 1'b0;
      dp_wr_q <= 1'b0;
      mem_q <= {`WORD_W{1'b0}};
      out_q <= 32'h00000000;
      ce_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      dp_wr_q <= take && hwrite_i && !(edac_on && subword);
      if (take)
      begin
        addr_q <= haddr_i[AW+1:2];
        be_q <= byte_en(hsize_i, haddr_i[1:0]);
        wr_q <= hwrite_i;
      end
      if ((state_q == S_RD) || (state_q == S_RMW_RD))
      begin
        mem_q <= mem[addr_q];
        out_q <= mem[addr_q][31:0];
      end
      if (decoding)
        out_q <= corrected;
      ce_q <= decoding && single_err;
    end
  end

  // ------------------------------------------------------------
  // memory write port
  // ------------------------------------------------------------
  reg mem_we;
  reg [4:0] mem_lanes;
  reg [`WORD_W-1:0] mem_wd;
  integer k;

  always @*
  begin
    mem_we = 1'b0;
    mem_lanes = 5'h00;
    mem_wd = {`WORD_W{1'b0}};
    if (scrub)
    begin
      mem_we = 1'b1;
      mem_lanes = 5'h1F;
      mem_wd = {encode(corrected), corrected};
    end
    else if (state_q == S_RMW_WR)
    begin
      mem_we = 1'b1;
      mem_lanes = 5'h1F;
      mem_wd = {(wb_q ? tcb_q : encode(rmw_data)), rmw_data};
    end
    else if (dp_wr_q)
    begin
      mem_we = 1'b1;
      mem_lanes = edac_on ? 5'h1F : {1'b0, be_q};
      mem_wd = {(wb_q ? tcb_q : encode(hwdata_i)), hwdata_i};
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (mem_we)
    begin
      for (k = 0; k < 4; k = k + 1)
        if (mem_lanes[k])
          mem[addr_q][k*8 +: 8] <= mem_wd[k*8 +: 8];
      if (mem_lanes[4])
        mem[addr_q][`CHK_MSB:`CHK_LSB] <= mem_wd[`CHK_MSB:`CHK_LSB];
    end
  end

  // ------------------------------------------------------------
  // configuration and error counter
  // ------------------------------------------------------------
  always @*
  begin
    cnt_d = cnt_q;
    if (cfg_wr_i)
      cnt_d = cnt_q & ~cfg_wdata_i[`CFG_CNT_MSB:`CFG_CNT_LSB];
    if (decoding && single_err && (cnt_d != `CNT_MAX))
      cnt_d = cnt_d + 8'h01;
  end

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_q <= `CFG_EN_RST;
      rb_q <= `CFG_RB_RST;
      wb_q <= `CFG_WB_RST;
      cnt_q <= `CNT_RST;
    end
    else
    begin
      if (cfg_wr_i && (EDAC_EN != 0))
      begin
        en_q <= cfg_wdata_i[`CFG_EN_BIT];
        rb_q <= cfg_wdata_i[`CFG_RB_BIT];
        wb_q <= cfg_wdata_i[`CFG_WB_BIT];
      end
      if ((ERRCNT_EN != 0) && (EDAC_EN != 0))
        cnt_q <= cnt_d;
    end
  end

  // test check bits are deliberately left out of reset
  always @(posedge sys_clk_i)
  begin
    if (decoding && rb_q)
      tcb_q <= mem_q[`CHK_MSB:`CHK_LSB];
    else if (cfg_wr_i)
      tcb_q <= cfg_wdata_i[`CFG_TCB_MSB:`CFG_TCB_LSB];
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata_o = out_q;
  assign ce_o = ce_q;
  assign cfg_rdata_o = (EDAC_EN == 0) ? 32'h00000000 :
    {11'h000, cnt_q, SIZE_LOG2[2:0], wb_q, rb_q, en_q, tcb_q};

endmodule
`default_nettype wire

/* File: edac_onchip_sram_ahb_tb.sv */
// self-checking bench for the protected sram
`timescale 1ns/100ps
`default_nettype none
module edac_onchip_sram_ahb_tb;
  logic sys_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic cfg_wr = 1'h0;
  logic [31:0] cfg_wd = 32'h0;
  wire logic hsel, hwrite, rdy, ce;
  wire logic [1:0] htrans, hresp;
  wire logic [2:0] hsize;
  wire logic [31:0] haddr, hwdata, hrdata, cfg_rd;
  logic [31:0] ref_mem [0:255];
  logic [31:0] rd, d, e, f;
  logic err;
  int fail_count = 0, cmp_count = 0, cyc = 0, ce_seen = 0, w, c0;
  always #10 sys_clk_i = ~sys_clk_i;
  edac_onchip_sram_ahb dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(hresp), .hrdata_o(hrdata), .cfg_wr_i(cfg_wr),
    .cfg_wdata_i(cfg_wd), .cfg_rdata_o(cfg_rd), .ce_o(ce));
  ahb_master_model mst (.clk_i(sys_clk_i), .ready_i(rdy), .resp_i(hresp), .rdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (ce === 1'h1)
      ce_seen++;
    if (cyc == 10000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cfg(input logic [31:0] v);
    @(posedge sys_clk_i);
    #1;
    cfg_wr = 1'h1;
    cfg_wd = v;
    @(posedge sys_clk_i);
    #1;
    cfg_wr = 1'h0;
  endtask
  // reference check bits, weight-three columns in ascending order
  function automatic logic [6:0] chk(input logic [31:0] x);
    logic [6:0] c;
    int j;
    c = 7'h00;
    j = 0;
    for (int v = 0; v < 128; v++)
      if ($countones(v[6:0]) == 3 && j < 32)
      begin
        if (x[j])
          c ^= v[6:0];
        j++;
      end
    return c;
  endfunction
  task automatic acc(input logic wr, input logic [2:0] sz, input logic [31:0] a,
    input logic [31:0] wd, input int we, input logic ee);
    mst.xfer(wr, sz, a, wd, rd, err, w);
    check("waits", w, we);
    check("error", err, ee);
    if (!wr && !err)
      check("rdata", rd, ref_mem[a[9:2]]);
    for (int b = 0; wr && b < 4; b++)
      if (sz == 3'h2 || (sz == 3'h1 && b[1] == a[1]) || (sz == 3'h0 && b[1:0] == a[1:0]))
        ref_mem[a[9:2]][8*b +: 8] = wd[8*b +: 8];
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(94));
    repeat (8) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'h1;
    check("cfg reset", cfg_rd & 32'h001FFF80, 32'h0);
    cfg(32'h80);
    for (int i = 0; i < 8; i++)
      acc(1'h1, 3'h2, 32'(4 * i), $urandom, 0, 1'h0);
    for (int i = 0; i < 6; i++)
      acc(1'h1, 3'(i / 4), 32'(i < 4 ? 5 * i : 6 * i - 8), $urandom, 2, 1'h0);
    for (int i = 0; i < 8; i++)
      acc(1'h0, 3'h2, 32'(4 * i), 0, 2, 1'h0);
    acc(1'h0, 3'h0, 32'h3, 0, 2, 1'h0);
    cfg(32'h0);
    for (int i = 0; i < 8; i++)
      acc(1'h0, 3'h2, 32'(4 * i), 0, 1, 1'h0);
    acc(1'h1, 3'h0, 32'h1D, $urandom, 0, 1'h0);
    d = ref_mem[1];
    e = ref_mem[2];
    f = ref_mem[4];
    acc(1'h1, 3'h2, 32'h4, d ^ 32'h00010000, 0, 1'h0);
    acc(1'h1, 3'h2, 32'h8, e ^ 32'h00000003, 0, 1'h0);
    acc(1'h1, 3'h2, 32'h10, f ^ 32'h80000000, 0, 1'h0);
    ref_mem[1] = d;
    ref_mem[4] = f;
    cfg(32'h180);
    c0 = ce_seen;
    acc(1'h0, 3'h2, 32'h4, 0, 2, 1'h0);
    check("count", cfg_rd[20:13], 8'h01);
    acc(1'h0, 3'h2, 32'h8, 0, 3, 1'h1);
    check("ce", ce_seen - c0, 1);
    check("tcb double", cfg_rd[6:0], chk(e));
    cfg(32'h280 | (chk(ref_mem[3]) ^ 7'h01));
    acc(1'h1, 3'h2, 32'hC, ref_mem[3], 0, 1'h0);
    cfg(32'h180);
    acc(1'h0, 3'h2, 32'hC, 0, 2, 1'h0);
    check("tcb", cfg_rd[6:0], chk(ref_mem[3]) ^ 7'h01);
    acc(1'h1, 3'h0, 32'h6, $urandom, 2, 1'h0);
    check("count", cfg_rd[20:13], 8'h03);
    for (int i = 0; i < 260; i++)
      acc(1'h0, 3'h2, 32'h10, 0, 2, 1'h0);
    check("count sat", cfg_rd[20:13], 8'hFF);
    cfg(32'h000B4080);
    check("count clear", cfg_rd[20:13], 8'hA5);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: edac_sram_chk.sv */
// port-level assertions for the protected sram
`timescale 1ns/100ps
`default_nettype none
`include "edac_sram_consts.vh"
module edac_sram_chk (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic [1:0] hresp_o,
  input wire logic cfg_wr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic ce_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire logic tk;
  wire logic er;
  wire logic en;
  assign tk = hreadyout_o && hsel_i && hready_i && htrans_i[1];
  assign er = hresp_o == `HRESP_ERROR;
  assign en = cfg_rdata_o[7];
  property p_err;
    er && !hreadyout_o |=> er && hreadyout_o;
  endproperty
  a_err: assert property (p_err) else $error("error reply not two cycles");
  property p_ce;
    ce_o |=> !ce_o;
  endproperty
  a_ce: assert property (p_ce) else $error("ce longer than one cycle");
  property p_clr;
    !ce_o && cfg_wr_i ##1 !ce_o |-> (cfg_rdata_o[20:13] & $past(cfg_wdata_i[20:13])) == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("count bits not cleared");
  property p_cfg;
    cfg_wr_i && hreadyout_o |=> cfg_rdata_o[9:0] == $past(cfg_wdata_i[9:0]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config write lost");
  property p_rd_off;
    tk && !hwrite_i && !en |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("plain read timing");
  property p_rd_on;
    tk && !hwrite_i && en |=> !hreadyout_o [*2] ##1 (hreadyout_o || er);
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("checked read timing");
  property p_wr_word;
    tk && hwrite_i && (hsize_i == `HSIZE_WORD || !en) |=> hreadyout_o;
  endproperty
  a_wr_word: assert property (p_wr_word) else $error("write waited");
  property p_wr_sub;
    tk && hwrite_i && hsize_i != `HSIZE_WORD && en |=> !hreadyout_o [*2] ##1 (hreadyout_o || er);
  endproperty
  a_wr_sub: assert property (p_wr_sub) else $error("subword write timing");
  cover property (er && hreadyout_o);
  cover property (ce_o);
  cover property (cfg_rdata_o[20:13] == 8'hFF);
endmodule
bind edac_onchip_sram_ahb edac_sram_chk u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cfg_wr_i(cfg_wr_i),
  .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .ce_o(ce_o));
`default_nettype wire

/* File: edac_sram_consts.vh */
// constants for the check-bit protected on-chip sram
`ifndef EDAC_SRAM_CONSTS_VH
`define EDAC_SRAM_CONSTS_VH

// data and check-bit widths
`define DATA_W 32
`define CHK_W 7
`define WORD_W 39
`define CHK_LSB 32
`define CHK_MSB 38

// memory sizing
`define WORDS_PER_KB 256

// ahb encodings
`define HTRANS_BUSY 2'h1
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 2'h0
`define HRESP_ERROR 2'h1

// configuration word field positions
`define CFG_TCB_LSB 0
`define CFG_TCB_MSB 6
`define CFG_EN_BIT 7
`define CFG_RB_BIT 8
`define CFG_WB_BIT 9
`define CFG_SIZE_LSB 10
`define CFG_SIZE_MSB 12
`define CFG_CNT_LSB 13
`define CFG_CNT_MSB 20

// configuration reset values
`define CFG_EN_RST 1'h0
`define CFG_RB_RST 1'h0
`define CFG_WB_RST 1'h0
`define CNT_RST 8'h00
`define CNT_MAX 8'hFF

`endif
